// *** bhf_pkg.sv ***
// Package for the bubble host FIFO and command port block.
// Assumes a single 40 MHz system clock and an Avalon-MM register slave.
package bhf_pkg;
  // Bus word offsets (byte addresses)
  localparam logic [3:0] BHF_OFF_DATA = 4'h0; // FIFO data port, port select low
  localparam logic [3:0] BHF_OFF_CMD = 4'h4; // Command write / status read, select high
  localparam logic [3:0] BHF_OFF_CTRL = 4'h8; // Parameter/config register
  localparam logic [3:0] BHF_OFF_PEEK = 4'hC; // FIFO count readback
  localparam int BHF_SEL_BIT = 2; // Address bit acting as port select
  // FIFO geometry
  localparam int BHF_FIFO_DEPTH = 40;
  localparam int BHF_CNT_W = 6;
  localparam logic [5:0] BHF_MIN_WRITE = 6'h02; // Bytes needed before normal write drains
  // Status byte fields
  localparam int BHF_ST_BUSY = 7;
  localparam int BHF_ST_DONE = 6;
  localparam int BHF_ST_FAIL = 5;
  localparam int BHF_ST_TIMING = 3;
  localparam int BHF_ST_PARITY = 1;
  localparam int BHF_ST_AVAIL = 0;
  localparam logic [7:0] BHF_ST_RESET = 8'h00;
  // Parameter register: [7:0] reset value
  localparam logic [7:0] BHF_PARAM_RESET = 8'h00;
  localparam logic [7:0] BHF_CFG_MASK = 8'hF0; // Configuration fields kept by soft reset
  // Timing
  localparam int BHF_CLK_MHZ = 40;
  localparam int BHF_PWRUP_US = 100; // Power-up sequence length
  localparam int BHF_PWRUP_CYC = BHF_PWRUP_US * BHF_CLK_MHZ;
  localparam int BHF_XFER_CYC = 4; // Divider count at which a fill from the formatter may end
  // Commands (four-bit code)
  typedef enum logic [3:0] {
    BHF_C_WLMAP_MASK = 4'h0,
    BHF_C_INIT = 4'h1,
    BHF_C_READ = 4'h2,
    BHF_C_WRITE = 4'h3,
    BHF_C_RSEEK = 4'h4,
    BHF_C_RLMREG = 4'h5,
    BHF_C_WLMREG = 4'h6,
    BHF_C_WLMAP = 4'h7,
    BHF_C_RSENSE = 4'h8,
    BHF_C_ABORT = 4'h9,
    BHF_C_WSEEK = 4'hA,
    BHF_C_RLMAP = 4'hB,
    BHF_C_RCORR = 4'hC,
    BHF_C_FIFO_CLR = 4'hD,
    BHF_C_PURGE = 4'hE,
    BHF_C_SOFT_RST = 4'hF
  } bhf_cmd_t;
  // Controller states
  typedef enum logic [2:0] {
    BHF_S_PWRUP = 3'b000,
    BHF_S_IDLE = 3'b001,
    BHF_S_WAIT2 = 3'b010,
    BHF_S_DRAIN = 3'b011,
    BHF_S_FILL = 3'b100,
    BHF_S_LMSRCH = 3'b101
  } bhf_state_t;
endpackage : bhf_pkg

// *** bhf_ctrl.sv ***
// Host FIFO, command decoder and status byte of a bubble memory controller.
// Assumes an Avalon-MM master on clk_sys and a formatter/sense channel
// presenting byte handshakes and error levels on the same clock.
// Function
// R01: FIFO clear command zeroes byte counter
// R02: Forty-byte FIFO usable as plain store
// R03: Normal write waits for two bytes
// R04: Loop-map writes drain FIFO immediately
// R05: Host clears, preloads, then issues loop-map write
// R06: Host polls busy and available for writes
// R07: Formatter errors latch into status until cleared
// R08: Soft reset clears errors, FIFO, keeps config
// R09: Initialize clears errors and all parameters
// R10: Status read with port select high
// R11: Power-up done low until sequence ends
// R12: Idle empty status reads operation complete
// R13: Full FIFO after host writes shows data bit
// R14: Emptied FIFO clears data bit
// R15: Initialize searches loop map, timing error otherwise
// R16: Abort completes with only operation done
// R17: Host may use abort plus purge instead
// R18: Busy top, done bit six, available bit zero
// R19: Sixteen commands from four-bit code
// R20: Select low reaches FIFO, high command port
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module bhf_ctrl
  import bhf_pkg::*;
#(
  parameter int PWRUP_CYC = BHF_PWRUP_CYC, // Shorten in simulation
  parameter int LMAP_TIMEOUT = 8192 // Cycles to look for the loop-map sync
)
(
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Formatter/sense channel, same clock
  output logic fmt_tx_valid,
  output logic [7:0] fmt_tx_data,
  input wire logic fmt_tx_ready,
  input wire logic fmt_rx_valid,
  input wire logic [7:0] fmt_rx_data,
  input wire logic fmt_error,
  input wire logic fmt_parity_error,
  input wire logic fmt_lmap_found,
  output logic pwrup_done
);

  // All block state in one record
  typedef struct packed {
    bhf_state_t st;
    logic [BHF_FIFO_DEPTH*8-1:0] mem; // FIFO storage, byte i at [8i+7:8i]
    logic [BHF_CNT_W-1:0] rd_ptr;
    logic [BHF_CNT_W-1:0] wr_ptr;
    logic [BHF_CNT_W-1:0] count;
    logic busy;
    logic done;
    logic fail;
    logic timing_err;
    logic parity_err;
    logic [7:0] param;
    logic [15:0] timer;
    logic [2:0] xfer_div;
    logic [31:0] rdata;
    logic ack;
    logic tx_valid;
    logic [7:0] tx_data;
    logic pdone;
  } bhf_regs_t;

  bhf_regs_t r;
  bhf_regs_t next_r;

  // Wrap a FIFO pointer at the depth
  function automatic logic [BHF_CNT_W-1:0] bhf_inc(input logic [BHF_CNT_W-1:0] p);
    bhf_inc = (p == BHF_CNT_W'(BHF_FIFO_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bhf_inc

  // Status byte assembly, also used for readback
  function automatic logic [7:0] bhf_status(input bhf_regs_t s);
    logic [7:0] v;
    v = BHF_ST_RESET;
    v[BHF_ST_BUSY] = s.busy; // R18
    v[BHF_ST_DONE] = s.done; // R18
    v[BHF_ST_FAIL] = s.fail;
    v[BHF_ST_TIMING] = s.timing_err;
    v[BHF_ST_PARITY] = s.parity_err;
    // While writing toward the formatter the bit means room, else data present
    if (s.st == BHF_S_WAIT2 || s.st == BHF_S_DRAIN)
      v[BHF_ST_AVAIL] = (s.count != BHF_CNT_W'(BHF_FIFO_DEPTH));
    else
      v[BHF_ST_AVAIL] = (s.count != '0); // R13 R14
    bhf_status = v;
  endfunction : bhf_status

  logic sel_hi;
  logic bus_req;
  logic [7:0] head;
  bhf_cmd_t cmd;

  assign sel_hi = avs_address[BHF_SEL_BIT];
  assign bus_req = (avs_read | avs_write) & ~r.ack;
  assign head = r.mem[r.rd_ptr*8 +: 8];
  assign cmd = bhf_cmd_t'(avs_writedata[3:0]);

  // Next-state logic for bus, FIFO, commands and status
  always_comb
  begin
    logic push;
    logic pop;
    logic [7:0] pdat;
    logic clr;
    push = 1'b0;
    pop = 1'b0;
    pdat = 8'h00;
    clr = 1'b0;
    next_r = r;
    next_r.ack = 1'b0;
    next_r.timer = r.timer + 1'b1;
    // One wait state per access keeps the read data registered
    if (bus_req)
    begin
      next_r.ack = 1'b1;
      if (!sel_hi && !avs_address[3])
      begin
        // Data port: plain byte store with no command needed
        if (avs_write && r.count != BHF_CNT_W'(BHF_FIFO_DEPTH))
        begin
          push = 1'b1; // R02 R20
          pdat = avs_writedata[7:0];
        end
        if (avs_read)
        begin
          next_r.rdata = {24'h000000, head};
          pop = (r.count != '0); // R02 R20
        end
      end
      else if (sel_hi && !avs_address[3])
      begin
        if (avs_read)
          next_r.rdata = {24'h000000, bhf_status(r)}; // R10 R20
        else if (r.st != BHF_S_PWRUP || cmd == BHF_C_INIT || cmd == BHF_C_ABORT)
        begin
          // Busy blocks all but abort; commands decoded from four bits
          if (!r.busy || cmd == BHF_C_ABORT)
          begin
            next_r.done = 1'b0;
            case (cmd) // R19
              BHF_C_FIFO_CLR:
              begin
                clr = 1'b1; // R01
                next_r.done = 1'b1;
              end
              BHF_C_SOFT_RST:
              begin
                clr = 1'b1; // R08
                next_r.fail = 1'b0;
                next_r.timing_err = 1'b0;
                next_r.parity_err = 1'b0;
                next_r.param = r.param & BHF_CFG_MASK; // R08
                next_r.done = 1'b1;
              end
              BHF_C_INIT:
              begin
                clr = 1'b1;
                next_r.fail = 1'b0; // R09
                next_r.timing_err = 1'b0;
                next_r.parity_err = 1'b0;
                next_r.param = BHF_PARAM_RESET; // R09
                next_r.busy = 1'b1;
                next_r.timer = '0;
                next_r.st = BHF_S_LMSRCH; // R15
              end
              BHF_C_ABORT, BHF_C_PURGE:
              begin
                // Abort ends any transfer and leaves only completion set
                next_r.busy = 1'b0;
                next_r.fail = 1'b0;
                next_r.timing_err = 1'b0;
                next_r.parity_err = 1'b0;
                next_r.tx_valid = 1'b0;
                next_r.done = 1'b1; // R16
                next_r.st = BHF_S_IDLE;
              end
              BHF_C_WRITE:
              begin
                next_r.busy = 1'b1;
                next_r.st = BHF_S_WAIT2; // R03
              end
              BHF_C_WLMAP_MASK, BHF_C_WLMREG, BHF_C_WLMAP:
              begin
                next_r.busy = 1'b1;
                next_r.st = BHF_S_DRAIN; // R04
              end
              BHF_C_READ, BHF_C_RLMREG, BHF_C_RLMAP, BHF_C_RCORR, BHF_C_RSENSE:
              begin
                next_r.busy = 1'b1;
                next_r.st = BHF_S_FILL;
              end
              default:
              begin
                // Seek commands have no FIFO activity here
                next_r.done = 1'b1;
              end
            endcase
          end
        end
      end
      else if (avs_address[3] && !sel_hi)
      begin
        if (avs_write)
          next_r.param = avs_writedata[7:0];
        next_r.rdata = {24'h000000, r.param};
      end
      else
        next_r.rdata = {26'h0, r.count};
    end
    // Formatter errors are sticky; set after the command decode so that
    // a hardware set beats a same-cycle clear by abort or reset commands
    if (r.busy && fmt_error)
    begin
      next_r.fail = 1'b1; // R07
    end
    if (fmt_parity_error)
    begin
      next_r.parity_err = 1'b1; // R07
    end
    // Controller sequencing
    next_r.xfer_div = r.xfer_div + 1'b1;
    case (r.st)
      BHF_S_PWRUP:
      begin
        if (32'(r.timer) >= PWRUP_CYC - 1)
        begin
          next_r.pdone = 1'b1; // R11
          next_r.done = 1'b1; // R12
          next_r.st = BHF_S_IDLE;
        end
      end
      BHF_S_IDLE:
      begin
        next_r.tx_valid = 1'b0;
      end
      BHF_S_WAIT2:
      begin
        if (r.count >= BHF_MIN_WRITE)
          next_r.st = BHF_S_DRAIN; // R03
      end
      BHF_S_DRAIN:
      begin
        if (r.tx_valid && fmt_tx_ready)
          next_r.tx_valid = 1'b0;
        else if (!r.tx_valid && r.count != '0 && !pop)
        begin
          next_r.tx_valid = 1'b1; // R04
          next_r.tx_data = head;
          pop = 1'b1;
        end
        else if (!r.tx_valid && r.count == '0)
        begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st = BHF_S_IDLE;
        end
      end
      BHF_S_FILL:
      begin
        if (fmt_rx_valid && r.count != BHF_CNT_W'(BHF_FIFO_DEPTH) && !push)
        begin
          push = 1'b1;
          pdat = fmt_rx_data;
        end
        if (r.xfer_div == 3'(BHF_XFER_CYC) && !fmt_rx_valid)
        begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st = BHF_S_IDLE;
        end
      end
      BHF_S_LMSRCH:
      begin
        if (fmt_lmap_found)
        begin
          next_r.busy = 1'b0;
          next_r.done = 1'b1;
          next_r.st = BHF_S_IDLE;
        end
        else if (32'(r.timer) >= LMAP_TIMEOUT - 1)
        begin
          next_r.timing_err = 1'b1; // R15
          next_r.fail = 1'b1;
          next_r.busy = 1'b0;
          next_r.st = BHF_S_IDLE;
        end
      end
      default:
      begin
        next_r.st = BHF_S_IDLE;
      end
    endcase
    // FIFO pointer update; a clear overrides any same-cycle move
    if (clr)
    begin
      next_r.rd_ptr = '0; // R01
      next_r.wr_ptr = '0;
      next_r.count = '0;
    end
    else
    begin
      if (push)
      begin
        next_r.mem[r.wr_ptr*8 +: 8] = pdat;
        next_r.wr_ptr = bhf_inc(r.wr_ptr);
      end
      if (pop)
        next_r.rd_ptr = bhf_inc(r.rd_ptr);
      if (push && !pop)
        next_r.count = r.count + 1'b1;
      else if (pop && !push)
        next_r.count = r.count - 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= BHF_S_PWRUP;
      r.param <= BHF_PARAM_RESET;
    end
    else
      r <= next_r;
  end

  // Outputs straight from flip-flops
  assign avs_readdata = r.rdata;
  assign avs_waitrequest = ~r.ack;
  assign fmt_tx_valid = r.tx_valid;
  assign fmt_tx_data = r.tx_data;
  assign pwrup_done = r.pdone;

endmodule : bhf_ctrl

// *** bhf_fmt_model.sv ***
// Behavioural formatter channel on the far side of the controller.
// Assumes the bench steers stalls, errors and loop-map sync by plain levels.
`timescale 1ns/1ps
module bhf_fmt_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic slow,
  input wire logic inj_err,
  input wire logic inj_par,
  input wire logic found,
  input wire logic fmt_tx_valid,
  input wire logic [7:0] fmt_tx_data,
  output logic fmt_tx_ready,
  output logic fmt_rx_valid,
  output logic [7:0] fmt_rx_data,
  output logic fmt_error,
  output logic fmt_parity_error,
  output logic fmt_lmap_found,
  output logic [7:0] got_cnt,
  output logic [7:0] got_last
);
  logic tog; // Stall pattern, also scrambles idle rx data
  // Count bytes taken from the controller
  always_ff @(posedge clk_sys)
  begin
    tog <= rst ? 1'b0 : ~tog;
    if (rst)
      got_cnt <= 8'h00;
    else if (fmt_tx_valid && fmt_tx_ready)
    begin
      got_cnt <= got_cnt + 8'h01;
      got_last <= fmt_tx_data;
    end
  end
  // Slow mode accepts every other cycle only
  assign fmt_tx_ready = slow ? tog : 1'b1;
  assign fmt_rx_valid = 1'b0;
  // Idle rx lines change each cycle so no stale value looks valid
  assign fmt_rx_data = {8{tog}} ^ 8'h5A;
  assign fmt_error = inj_err;
  assign fmt_parity_error = inj_par;
  assign fmt_lmap_found = found;
endmodule : bhf_fmt_model

// *** bhf_ctrl_monitor.sv ***
// Checker of the controller ports, bound into every bhf_ctrl.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module bhf_ctrl_monitor
#(
  parameter int PWRUP_CYC = 20
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fmt_tx_valid,
  input wire logic [7:0] fmt_tx_data,
  input wire logic fmt_tx_ready,
  input wire logic pwrup_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic acc; // Access accepted this edge
  logic [3:0] last_cmd;
  logic [5:0] nbytes; // Data writes since the last FIFO clear or soft reset command
  logic fail_seen; // Last status read since the last command write showed fail
  int pcnt; // Cycles since reset, saturating
  assign acc = !avs_waitrequest && (avs_read || avs_write);
  // Track commands, data writes and status reads
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      last_cmd <= 4'h0;
      nbytes <= 6'h00;
      fail_seen <= 1'b0;
      pcnt <= 0;
    end
    else
    begin
      if (pcnt < PWRUP_CYC + 8)
        pcnt <= pcnt + 1;
      if (acc && avs_write && avs_address == 4'h4)
      begin
        last_cmd <= avs_writedata[3:0];
        fail_seen <= 1'b0;
        if (avs_writedata[3:0] inside {4'hD, 4'hF})
          nbytes <= 6'h00;
      end
      else if (acc && avs_write && avs_address == 4'h0 && nbytes < 6'h3F)
        nbytes <= nbytes + 6'h01;
      else if (acc && avs_read && avs_address == 4'h4)
        fail_seen <= avs_readdata[5];
    end
  end
  a_ack_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_pwrup_in_reset: assert property (disable iff (1'b0) rst |=> !pwrup_done)
    else $error("power-up done high after reset");
  a_pwrup_stays: assert property (pwrup_done |=> pwrup_done)
    else $error("power-up done fell");
  a_pwrup_not_early: assert property ($rose(pwrup_done) |-> pcnt >= PWRUP_CYC - 2)
    else $error("power-up done too early");
  a_pwrup_not_late: assert property (pcnt == PWRUP_CYC + 4 |-> pwrup_done)
    else $error("power-up done too late");
  a_tx_hold: assert property (fmt_tx_valid && !fmt_tx_ready |=>
    fmt_tx_valid && $stable(fmt_tx_data))
    else $error("formatter byte dropped before ready");
  a_write_two_bytes: assert property ($rose(fmt_tx_valid) && last_cmd == 4'h3 |->
    nbytes >= 6'h02)
    else $error("write drained before two bytes");
  a_fail_sticky: assert property (acc && avs_read && avs_address == 4'h4 && fail_seen |->
    avs_readdata[5])
    else $error("fail flag lost without a command");
endmodule : bhf_ctrl_monitor
bind bhf_ctrl bhf_ctrl_monitor #(.PWRUP_CYC(PWRUP_CYC)) bhf_ctrl_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .fmt_tx_valid(fmt_tx_valid),
  .fmt_tx_data(fmt_tx_data), .fmt_tx_ready(fmt_tx_ready), .pwrup_done(pwrup_done));

// *** bhf_ctrl_test.sv ***
// Self-checking bench of bhf_ctrl with a formatter model.
// Assumes short power-up and loop-map counts set by parameter.
`timescale 1ns/1ps
`define CHK(n, e, v) begin checked++; if ((v) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %h got %h", n, e, v); end end
module bhf_ctrl_test;
  import bhf_pkg::*;
  typedef struct packed {bhf_cmd_t c; logic [7:0] s;} bhf_row_t;
  bhf_row_t rows [7] = '{'{BHF_C_FIFO_CLR, 8'h40}, '{BHF_C_SOFT_RST, 8'h40},
    '{BHF_C_ABORT, 8'h40}, '{BHF_C_PURGE, 8'h40}, '{BHF_C_WSEEK, 8'h40},
    '{BHF_C_RSEEK, 8'h40}, '{BHF_C_READ, 8'h40}};
  logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic slow = 1'b0, inj_err = 1'b0, inj_par = 1'b0, found = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, fmt_tx_valid, fmt_tx_ready, fmt_rx_valid, fmt_error;
  logic fmt_parity_error, fmt_lmap_found, pwrup_done;
  logic [7:0] fmt_tx_data, fmt_rx_data, got_cnt, got_last, rd, n;
  int fail_count = 0, checked = 0, cyc = 0, i;
  bhf_ctrl #(.PWRUP_CYC(20), .LMAP_TIMEOUT(50)) bhf_ctrl_i (.*);
  bhf_fmt_model bhf_fmt_model_i (.*);
  // 40 MHz clock
  initial forever #12.5 clk_sys = ~clk_sys;
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end
  // One bus access held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    if (wr)
      avs_write <= 1'b1;
    else
      avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Status polling, bounded
  task poll(input logic [7:0] m, input logic [7:0] v);
    int t;
    for (t = 0; t < 300; t++)
    begin
      bus(1'b0, BHF_OFF_CMD, 8'h00);
      if ((rd & m) === v) break;
    end
    // A status that never arrives counts as a mismatch
    if (t == 300)
      fail_count++;
  endtask : poll
  task stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    `CHK("pwrup_rst", 1'b0, pwrup_done)
    rst <= 1'b0;
    for (i = 0; i < 60 && pwrup_done !== 1'b1; i++) @(posedge clk_sys);
    `CHK("pwrup_done", 1'b1, pwrup_done)
    bus(1'b1, BHF_OFF_CTRL, 8'h10);
    poll(8'h00, 8'h00);
    `CHK("st_idle", 8'h40, rd)
    // 41st byte is refused by a full store
    for (i = 0; i < 41; i++) bus(1'b1, BHF_OFF_DATA, 8'h01 + i[7:0]);
    poll(8'h00, 8'h00);
    `CHK("st_full", 8'h41, rd)
    bus(1'b0, BHF_OFF_PEEK, 8'h00);
    `CHK("count", 8'h28, rd)
    for (i = 0; i < 40; i++)
    begin
      bus(1'b0, BHF_OFF_DATA, 8'h00);
      `CHK("fifo_data", 8'h01 + i[7:0], rd)
    end
    poll(8'h00, 8'h00);
    `CHK("st_empty", 8'h40, rd)
    for (i = 0; i < 3; i++) bus(1'b1, BHF_OFF_DATA, 8'h33);
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_FIFO_CLR});
    bus(1'b0, BHF_OFF_PEEK, 8'h00);
    `CHK("count_clr", 8'h00, rd)
    foreach (rows[k])
    begin
      bus(1'b1, BHF_OFF_CMD, {4'h0, rows[k].c});
      poll(8'h80, 8'h00);
      `CHK("cmd_status", rows[k].s, rd)
    end
    // Loop-map write drains a preloaded store against a stalling far side
    slow <= 1'b1;
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_FIFO_CLR});
    for (i = 0; i < 3; i++) bus(1'b1, BHF_OFF_DATA, 8'hC1 + i[7:0]);
    n = got_cnt;
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_WLMAP});
    poll(8'h80, 8'h00);
    `CHK("lmap_cnt", n + 8'h03, got_cnt)
    `CHK("lmap_last", 8'hC3, got_last)
    slow <= 1'b0;
    // Normal write holds off until two bytes are in
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_FIFO_CLR});
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_WRITE});
    poll(8'h81, 8'h81);
    n = got_cnt;
    bus(1'b1, BHF_OFF_DATA, 8'h77);
    repeat (20) @(posedge clk_sys);
    `CHK("wr_one", n, got_cnt)
    bus(1'b1, BHF_OFF_DATA, 8'h78);
    poll(8'h80, 8'h00);
    `CHK("wr_two", n + 8'h02, got_cnt)
    // Formatter error latches, abort ends clean
    inj_err <= 1'b1;
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_WRITE});
    poll(8'h20, 8'h20);
    `CHK("fail_set", 1'b1, rd[5])
    inj_err <= 1'b0;
    poll(8'h00, 8'h00);
    `CHK("fail_keep", 1'b1, rd[5])
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_ABORT});
    poll(8'h80, 8'h00);
    `CHK("abort", 8'h40, rd)
    // Soft reset clears flags and store, keeps configuration
    inj_par <= 1'b1;
    @(posedge clk_sys);
    inj_par <= 1'b0;
    poll(8'h00, 8'h00);
    `CHK("par_set", 1'b1, rd[1])
    bus(1'b1, BHF_OFF_DATA, 8'h11);
    bus(1'b1, BHF_OFF_CTRL, 8'hA5);
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_SOFT_RST});
    poll(8'h80, 8'h00);
    `CHK("soft_st", 8'h40, rd)
    bus(1'b0, BHF_OFF_PEEK, 8'h00);
    `CHK("soft_cnt", 8'h00, rd)
    bus(1'b0, BHF_OFF_CTRL, 8'h00);
    `CHK("soft_cfg", 8'hA0, rd)
    // Initialize without loop-map sync, then with it
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_INIT});
    poll(8'h80, 8'h00);
    `CHK("init_timing", 1'b1, rd[3])
    bus(1'b0, BHF_OFF_CTRL, 8'h00);
    `CHK("init_param", 8'h00, rd)
    // Abort then purge stands in for a failed initialize, leaving no errors
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_ABORT});
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_PURGE});
    poll(8'h80, 8'h00);
    `CHK("abort_purge", 8'h40, rd)
    found <= 1'b1;
    bus(1'b1, BHF_OFF_CMD, {4'h0, BHF_C_INIT});
    poll(8'h80, 8'h00);
    `CHK("init_ok", 8'h40, rd)
    // Mid-run reset restarts the power-up sequence
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("pwrup_rerst", 1'b0, pwrup_done)
    rst <= 1'b0;
    for (i = 0; i < 60 && pwrup_done !== 1'b1; i++) @(posedge clk_sys);
    `CHK("pwrup_again", 1'b1, pwrup_done)
    stop_test();
  end
endmodule : bhf_ctrl_test
